//--- common/fsp_pkg.sv
/*
  Constants shared by the framed serial port pin control: register map,
  control and status fields, reset values, bit clock limits.
  Assumes a 200 MHz system clock and 32-bit AHB-Lite data.
*/
package fsp_pkg;
  // System clock and bit clock limits
  localparam int CLK_SYS_HZ     = 200_000_000;
  localparam int BIT_CLK_MIN_HZ = 512_000;
  localparam int BIT_CLK_MAX_HZ = 8_192_000;
  // Half periods of the generated bit clock, in system cycles
  localparam int HALF_MIN_CYC = (CLK_SYS_HZ + 2 * BIT_CLK_MAX_HZ - 1) / (2 * BIT_CLK_MAX_HZ);
  localparam int HALF_MAX_CYC = CLK_SYS_HZ / (2 * BIT_CLK_MIN_HZ);
  localparam int DIV_W        = 16;
  localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(HALF_MIN_CYC);
  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(HALF_MAX_CYC);
  localparam logic [DIV_W-1:0] DIV_RST = DIV_W'(HALF_MAX_CYC);
  // Data path
  localparam int WORD_W     = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int BITCNT_W   = 5;
  localparam logic [BITCNT_W-1:0] BIT_LAST = 5'h1f;
  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_DIV    = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STAT   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_TXDATA = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_RXDATA = 8'h10;
  // Control fields
  localparam int CTRL_W      = 8;
  localparam int CTRL_EN     = 0;
  localparam int CTRL_TXCLKO = 1;
  localparam int CTRL_TXFSO  = 2;
  localparam int CTRL_RXCLKO = 3;
  localparam int CTRL_RXFSO  = 4;
  localparam int CTRL_TXFALL = 5;
  localparam int CTRL_RXFALL = 6;
  localparam int CTRL_FUSE   = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  // Status fields
  localparam int STAT_RXVALID = 0;
  localparam int STAT_RXOVR   = 1;
  localparam int STAT_TXEMPTY = 2;
  localparam int STAT_TXFULL  = 3;
  localparam int STAT_FUSE    = 4;
endpackage : fsp_pkg

//--- common/fsp_stream_if.sv
/*
  Valid/ready word stream between the port's own modules.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface fsp_stream_if #(parameter int W = 32) ();
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : fsp_stream_if

//--- design/fsp_fifo.sv
/*
  Synchronous word FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module fsp_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  // System
  input wire logic   clk_sys,
  input wire logic   rst,
  // Streams
  fsp_stream_if.snk  wr,
  fsp_stream_if.src  rd
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [AW:0]  wrPtr_q, wrPtr_d;
  logic [AW:0]  rdPtr_q, rdPtr_d;
  logic         full;
  logic         empty;

  // Extra pointer bit tells full from empty
  assign empty    = (wrPtr_q == rdPtr_q);
  assign full     = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) && (wrPtr_q[AW] != rdPtr_q[AW]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem_q[rdPtr_q[AW-1:0]];

  // Next pointers and storage
  always_comb begin
    mem_d   = mem_q;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    if (wr.valid && !full) begin
      mem_d[wrPtr_q[AW-1:0]] = wr.data;
      wrPtr_d                = wrPtr_q + 1'b1;
    end
    if (rd.ready && !empty) begin
      rdPtr_d = rdPtr_q + 1'b1;
    end
  end

  // Storage is not reset; pointers are
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    mem_q <= mem_d;
  end
endmodule : fsp_fifo

//--- design/fsp_port_pins.sv
/*
  Framed serial port pin control: bit clock and frame sync pins of either
  direction, selectable launch and sample edges, open-drain transmit data,
  32-bit frames fed from an 8-word FIFO, AHB-Lite register slave.
  Assumes external pins are asynchronous to clk_sys and slow enough
  (at most 8.192 MHz) to be oversampled at 200 MHz.
*/
//
// Contract
// - Transmit frame sync pin works as input or as driven output.
// - Receive frame sync pin works as input or as driven output.
// - Transmit bit clock pin is input or output, times data, 512 KHz to 8.192 MHz.
// - Receive bit clock pin is input or output, times sampling, within same range.
// - After reset all clock and frame sync pins are inputs, nothing driven.
// - Transmit data and frame sync launch on selected transmit clock edge.
// - Receive data sampled on selected receive clock edge.
// - Transmit data is open drain: pull low for zero, release for one.
// - Soft fuse set makes the whole port inactive.
`timescale 1ns/1ps
module fsp_port_pins (
  // System
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // AHB-Lite slave
  input  wire logic                          hsel,
  input  wire logic [fsp_pkg::ADDR_W-1:0]    haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [fsp_pkg::WORD_W-1:0]    hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic [fsp_pkg::WORD_W-1:0]         hrdata,
  output logic                               hresp,
  // Transmit pins
  input  wire logic                          txBitClock,
  output logic                               txBitClockDrive,
  output logic                               txBitClockOe,
  input  wire logic                          txFrameSync,
  output logic                               txFrameSyncDrive,
  output logic                               txFrameSyncOe,
  output logic                               txSerialOut,
  output logic                               txSerialOutOe,
  // Receive pins
  input  wire logic                          rxBitClock,
  output logic                               rxBitClockDrive,
  output logic                               rxBitClockOe,
  input  wire logic                          rxFrameSync,
  output logic                               rxFrameSyncDrive,
  output logic                               rxFrameSyncOe,
  input  wire logic                          rxSerialIn
);
  import fsp_pkg::*;

  localparam int PIN_N = 5;
  localparam int P_TXCLK = 0;
  localparam int P_TXFS  = 1;
  localparam int P_RXCLK = 2;
  localparam int P_RXFS  = 3;
  localparam int P_RXDAT = 4;

  // Rising or falling event, as chosen by a select bit
  function automatic logic edgeSel(input logic rise, input logic fall, input logic useFall);
    edgeSel = useFall ? fall : rise;
  endfunction : edgeSel

  fsp_stream_if #(.W(WORD_W)) txIn ();
  fsp_stream_if #(.W(WORD_W)) txOut ();

  fsp_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) uTxFifo (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wr      (txIn),
    .rd      (txOut)
  );

  logic [CTRL_W-1:0]   ctrl_q, ctrl_d;
  logic [DIV_W-1:0]    div_q, div_d;
  logic                run;
  logic [PIN_N-1:0]    sync1_q, sync2_q, sync3_q, lvl_q, lvl_d, pinRise, pinFall;
  logic [DIV_W-1:0]    divCnt_q, divCnt_d;
  logic                clkGen_q, clkGen_d, genRise, genFall;
  logic                txLaunch, rxSample, rxLaunch;
  logic                txRise, txFall, rxRise, rxFall;

  assign run = ctrl_q[CTRL_EN] && !ctrl_q[CTRL_FUSE];

  // Pin synchronisers: a change counts once stages two and three agree
  always_comb begin
    lvl_d = ((sync2_q ~^ sync3_q) & sync3_q) | ((sync2_q ^ sync3_q) & lvl_q);
  end
  assign pinRise = lvl_d & ~lvl_q;
  assign pinFall = ~lvl_d & lvl_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_q <= '1; // Pins idle high through their pull-ups
      sync2_q <= '1;
      sync3_q <= '1;
      lvl_q   <= '1;
    end else begin
      sync1_q <= {rxSerialIn, rxFrameSync, rxBitClock, txFrameSync, txBitClock};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lvl_q   <= lvl_d;
    end
  end

  // Bit clock generator, shared by both directions when they drive
  always_comb begin
    divCnt_d = divCnt_q;
    clkGen_d = clkGen_q;
    if (!run) begin
      divCnt_d = '0;
      clkGen_d = 1'b0;
    end else if (divCnt_q >= div_q - 1'b1) begin
      divCnt_d = '0;
      clkGen_d = !clkGen_q;
    end else begin
      divCnt_d = divCnt_q + 1'b1;
    end
  end
  assign genRise = clkGen_d && !clkGen_q;
  assign genFall = !clkGen_d && clkGen_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      divCnt_q <= '0;
      clkGen_q <= 1'b0;
    end else begin
      divCnt_q <= divCnt_d;
      clkGen_q <= clkGen_d;
    end
  end

  // Edge events from the pin or from the generator
  assign txRise   = ctrl_q[CTRL_TXCLKO] ? genRise : pinRise[P_TXCLK];
  assign txFall   = ctrl_q[CTRL_TXCLKO] ? genFall : pinFall[P_TXCLK];
  assign rxRise   = ctrl_q[CTRL_RXCLKO] ? genRise : pinRise[P_RXCLK];
  assign rxFall   = ctrl_q[CTRL_RXCLKO] ? genFall : pinFall[P_RXCLK];
  assign txLaunch = run && edgeSel(txRise, txFall, ctrl_q[CTRL_TXFALL]);
  assign rxSample = run && edgeSel(rxRise, rxFall, ctrl_q[CTRL_RXFALL]);
  assign rxLaunch = run && edgeSel(rxRise, rxFall, !ctrl_q[CTRL_RXFALL]);

  // Transmit framer
  logic [WORD_W-1:0]   txShift_q, txShift_d;
  logic [BITCNT_W-1:0] txCnt_q, txCnt_d;
  logic                txActive_q, txActive_d, txStart;
  logic                txOdOe_q, txOdOe_d, txFs_q, txFs_d;
  logic [WORD_W-1:0]   txWord;

  // Input sync is sampled as it stood just before the launch edge
  assign txStart = ctrl_q[CTRL_TXFSO] ? (!txActive_q || txCnt_q == BIT_LAST) : lvl_q[P_TXFS];
  assign txOut.ready = txLaunch && txStart;
  // An empty FIFO sends all ones, which leaves the line released
  assign txWord = txOut.valid ? txOut.data : '1;

  always_comb begin
    txShift_d  = txShift_q;
    txCnt_d    = txCnt_q;
    txActive_d = txActive_q;
    txOdOe_d   = txOdOe_q;
    txFs_d     = txFs_q;
    if (!run) begin
      txActive_d = 1'b0;
      txOdOe_d   = 1'b0;
      txFs_d     = 1'b0;
      txCnt_d    = '0;
    end else if (txLaunch) begin
      txFs_d = ctrl_q[CTRL_TXFSO] && txStart;
      if (txStart) begin
        txShift_d  = {txWord[WORD_W-2:0], 1'b0};
        txOdOe_d   = !txWord[WORD_W-1];
        txCnt_d    = '0;
        txActive_d = 1'b1;
      end else if (txActive_q && txCnt_q != BIT_LAST) begin
        txShift_d = {txShift_q[WORD_W-2:0], 1'b0};
        txOdOe_d  = !txShift_q[WORD_W-1];
        txCnt_d   = txCnt_q + 1'b1;
      end else begin
        txActive_d = 1'b0;
        txOdOe_d   = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txShift_q  <= '0;
      txCnt_q    <= '0;
      txActive_q <= 1'b0;
      txOdOe_q   <= 1'b0;
      txFs_q     <= 1'b0;
    end else begin
      txShift_q  <= txShift_d;
      txCnt_q    <= txCnt_d;
      txActive_q <= txActive_d;
      txOdOe_q   <= txOdOe_d;
      txFs_q     <= txFs_d;
    end
  end

  // Receive framer; generated sync launches on the edge opposite sampling
  logic [WORD_W-1:0]   rxShift_q, rxShift_d, rxWord_q, rxWord_d;
  logic [BITCNT_W-1:0] rxCnt_q, rxCnt_d, rxGenCnt_q, rxGenCnt_d;
  logic                rxActive_q, rxActive_d, rxFs_q, rxFs_d, rxFsSeen, rxDone;
  logic                rxValid_q, rxValid_d, rxOvr_q, rxOvr_d, rdRxData, clrOvr;

  assign rxFsSeen = ctrl_q[CTRL_RXFSO] ? rxFs_q : lvl_q[P_RXFS];
  assign rxDone   = rxSample && !rxFsSeen && rxActive_q && rxCnt_q == BIT_LAST;

  always_comb begin
    rxShift_d  = rxShift_q;
    rxCnt_d    = rxCnt_q;
    rxActive_d = rxActive_q;
    rxWord_d   = rxWord_q;
    rxGenCnt_d = rxGenCnt_q;
    rxFs_d     = rxFs_q;
    if (!run) begin
      rxActive_d = 1'b0;
      rxGenCnt_d = '0;
      rxFs_d     = 1'b0;
    end else begin
      if (rxLaunch) begin
        rxFs_d     = ctrl_q[CTRL_RXFSO] && rxGenCnt_q == '0;
        rxGenCnt_d = rxGenCnt_q + 1'b1;
      end
      if (rxSample) begin
        rxShift_d = {rxShift_q[WORD_W-2:0], lvl_q[P_RXDAT]};
        if (rxFsSeen) begin
          rxCnt_d    = 5'h01;
          rxActive_d = 1'b1;
        end else if (rxActive_q) begin
          rxCnt_d = rxCnt_q + 1'b1;
          if (rxCnt_q == BIT_LAST) begin
            rxWord_d   = {rxShift_q[WORD_W-2:0], lvl_q[P_RXDAT]};
            rxActive_d = 1'b0;
          end
        end
      end
    end
  end

  // Completion wins over a clear in the same cycle
  always_comb begin
    rxValid_d = (rxValid_q && !rdRxData) || rxDone;
    rxOvr_d   = (rxOvr_q && !clrOvr) || (rxDone && rxValid_q && !rdRxData);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxShift_q  <= '0;
      rxCnt_q    <= '0;
      rxActive_q <= 1'b0;
      rxWord_q   <= '0;
      rxGenCnt_q <= '0;
      rxFs_q     <= 1'b0;
      rxValid_q  <= 1'b0;
      rxOvr_q    <= 1'b0;
    end else begin
      rxShift_q  <= rxShift_d;
      rxCnt_q    <= rxCnt_d;
      rxActive_q <= rxActive_d;
      rxWord_q   <= rxWord_d;
      rxGenCnt_q <= rxGenCnt_d;
      rxFs_q     <= rxFs_d;
      rxValid_q  <= rxValid_d;
      rxOvr_q    <= rxOvr_d;
    end
  end

  // Pin direction registers; all released while the port is off
  logic txClkOe_q, txFsOe_q, rxClkOe_q, rxFsOe_q;
  logic txClkOe_d, txFsOe_d, rxClkOe_d, rxFsOe_d;
  always_comb begin
    txClkOe_d = run && ctrl_q[CTRL_TXCLKO];
    txFsOe_d  = run && ctrl_q[CTRL_TXFSO];
    rxClkOe_d = run && ctrl_q[CTRL_RXCLKO];
    rxFsOe_d  = run && ctrl_q[CTRL_RXFSO];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txClkOe_q <= 1'b0;
      txFsOe_q  <= 1'b0;
      rxClkOe_q <= 1'b0;
      rxFsOe_q  <= 1'b0;
    end else begin
      txClkOe_q <= txClkOe_d;
      txFsOe_q  <= txFsOe_d;
      rxClkOe_q <= rxClkOe_d;
      rxFsOe_q  <= rxFsOe_d;
    end
  end

  // AHB-Lite slave: one wait state, more while the FIFO is full
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              wr_q, wr_d, pend_q, pend_d, hrdy_q, hrdy_d, done;
  logic [WORD_W-1:0] rdata_q, rdata_d, stat;

  assign stat = WORD_W'({ctrl_q[CTRL_FUSE], !txIn.ready, !txOut.valid, rxOvr_q, rxValid_q});
  // A full FIFO stalls the bus until a word leaves
  assign done        = pend_q && !(wr_q && addr_q == REG_TXDATA && !txIn.ready);
  assign txIn.valid  = pend_q && wr_q && addr_q == REG_TXDATA;
  assign txIn.data   = hwdata;
  assign rdRxData    = done && !wr_q && addr_q == REG_RXDATA;
  assign clrOvr      = done && wr_q && addr_q == REG_STAT && hwdata[STAT_RXOVR];

  always_comb begin
    addr_d  = addr_q;
    wr_d    = wr_q;
    pend_d  = pend_q;
    hrdy_d  = hrdy_q;
    rdata_d = rdata_q;
    ctrl_d  = ctrl_q;
    div_d   = div_q;
    if (done) begin
      pend_d = 1'b0;
      hrdy_d = 1'b1;
      if (wr_q) begin
        unique case (addr_q)
          // Fuse bit is sticky until reset
          REG_CTRL: ctrl_d = hwdata[CTRL_W-1:0] | (ctrl_q & CTRL_W'(1 << CTRL_FUSE));
          // Out-of-range divisors are clamped to the legal clock range
          REG_DIV:  div_d  = (hwdata[DIV_W-1:0] < DIV_MIN) ? DIV_MIN :
                             (hwdata[DIV_W-1:0] > DIV_MAX) ? DIV_MAX : hwdata[DIV_W-1:0];
          default:  ctrl_d = ctrl_q;
        endcase
      end else begin
        unique case (addr_q)
          REG_CTRL:   rdata_d = WORD_W'(ctrl_q);
          REG_DIV:    rdata_d = WORD_W'(div_q);
          REG_STAT:   rdata_d = stat;
          REG_RXDATA: rdata_d = rxWord_q;
          default:    rdata_d = '0;
        endcase
      end
    end else if (!pend_q && hsel && hready && htrans[1]) begin
      addr_d = haddr;
      wr_d   = hwrite;
      pend_d = 1'b1;
      hrdy_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_q  <= '0;
      wr_q    <= 1'b0;
      pend_q  <= 1'b0;
      hrdy_q  <= 1'b1;
      rdata_q <= '0;
      ctrl_q  <= CTRL_RST;
      div_q   <= DIV_RST;
    end else begin
      addr_q  <= addr_d;
      wr_q    <= wr_d;
      pend_q  <= pend_d;
      hrdy_q  <= hrdy_d;
      rdata_q <= rdata_d;
      ctrl_q  <= ctrl_d;
      div_q   <= div_d;
    end
  end

  // Outputs, each from a flip-flop
  logic zero_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      zero_q <= 1'b0;
    end else begin
      zero_q <= 1'b0;
    end
  end
  assign hreadyout        = hrdy_q;
  assign hrdata           = rdata_q;
  assign hresp            = zero_q;
  assign txBitClockDrive  = clkGen_q;
  assign txBitClockOe     = txClkOe_q;
  assign txFrameSyncDrive = txFs_q;
  assign txFrameSyncOe    = txFsOe_q;
  assign txSerialOut      = zero_q;
  assign txSerialOutOe    = txOdOe_q;
  assign rxBitClockDrive  = clkGen_q;
  assign rxBitClockOe     = rxClkOe_q;
  assign rxFrameSyncDrive = rxFs_q;
  assign rxFrameSyncOe    = rxFsOe_q;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence sTxFrameStart;
    txLaunch && txStart && ctrl_q[CTRL_TXFSO];
  endsequence
  // Generated sync stands a whole bit period, far longer than two cycles
  sequence sTxSyncPulse;
    txFs_q [*2];
  endsequence

  a_idle_inputs: assert property (!run |=> !(txClkOe_q || txFsOe_q || rxClkOe_q || rxFsOe_q))
    else $error("pin driven while port off");
  a_fuse_silent: assert property (ctrl_q[CTRL_FUSE] |=> !txOdOe_q [*2])
    else $error("fused port still pulls data low");
  a_txfs_dir: assert property (run |=> txFrameSyncOe == $past(ctrl_q[CTRL_TXFSO]))
    else $error("tx frame sync direction wrong");
  a_rxfs_dir: assert property (run |=> rxFrameSyncOe == $past(ctrl_q[CTRL_RXFSO]))
    else $error("rx frame sync direction wrong");
  a_txclk_half: assert property ((run && $rose(clkGen_q)) |-> ##[13:195] ($fell(clkGen_q) || !run))
    else $error("generated clock half period out of range");
  a_rxclk_dir: assert property (run |=> rxBitClockOe == $past(ctrl_q[CTRL_RXCLKO]))
    else $error("rx clock direction wrong");
  a_tx_launch: assert property ((run && $changed(txOdOe_q) && $past(run)) |-> $past(txLaunch))
    else $error("tx data changed off the launch edge");
  a_rx_sample: assert property (rxDone |=> rxValid_q && rxWord_q[0] == $past(lvl_q[P_RXDAT]))
    else $error("rx word not captured at sample edge");
  a_od_pull: assert property ((txOut.ready && txOut.valid && !txOut.data[WORD_W-1]) |=> txOdOe_q && !txSerialOut)
    else $error("zero bit not pulled low");
  a_fs_align: assert property (sTxFrameStart |=> sTxSyncPulse)
    else $error("tx frame sync not raised at frame start");
  a_rxfs_align: assert property ((run && $past(run) && $changed(rxFs_q)) |-> $past(rxLaunch))
    else $error("rx frame sync moved off launch edge");
endmodule : fsp_port_pins

//--- verif/fsp_far_end.sv
/*
  Far-end serial device model: captures the port's transmit frames and
  sources receive frames on a bit clock of its own.
  Assumes the bench resolves every pin with its pull-up before it gets here.
*/
`timescale 1ns/1ps
module fsp_far_end (
  // Transmit pins, resolved
  input  wire logic   txClk,
  input  wire logic   txSync,
  input  wire logic   txLine,
  input  wire logic   txFall,
  // Receive pins driven here
  output logic        rxClk,
  output logic        rxSync,
  output logic        rxData,
  // Captured frames
  output logic [31:0] capWord,
  output int          capCount
);
  logic [31:0] shift;
  int          nBits;

  // Idle pins sit at the pull-up level
  initial begin
    rxClk = 1'b1;
    rxSync = 1'b1;
    rxData = 1'b1;
    capCount = 0;
    nBits = 0;
  end

  // Sample on the edge opposite the launch edge; sync restarts the count
  always @(txClk) begin
    if (txClk == txFall) begin
      shift = {shift[30:0], txLine};
      nBits = txSync ? 1 : nBits + 1;
      if (nBits == 32) begin
        capWord = shift;
        capCount++;
      end
    end
  end

  // One frame MSB first; clock stands still outside the frame
  task automatic send(input logic [31:0] w, input logic fall);
    for (int i = 31; i >= 0; i--) begin
      rxClk <= fall;
      rxData <= w[i];
      rxSync <= (i == 31);
      #32;
      rxClk <= ~fall;
      #32;
    end
    rxClk <= 1'b1;
    rxSync <= 1'b1;
    rxData <= 1'b1;
  endtask : send
endmodule : fsp_far_end

//--- verif/fsp_port_pins_tb.sv
/*
  Self-checking bench for the framed serial port pin control.
  Assumes pull-ups on all clock, sync and data pins and the far-end model.
*/
`timescale 1ns/1ps
module fsp_port_pins_tb;
  import fsp_pkg::*;
  logic              clk_sys = 1'b0;
  logic              rst, hsel, hwrite, hreadyout, hresp, txFall;
  logic [ADDR_W-1:0] haddr;
  logic [1:0]        htrans;
  logic [WORD_W-1:0] hwdata, hrdata, capWord, rdv;
  logic              txBitClockDrive, txBitClockOe, txFrameSyncDrive, txFrameSyncOe;
  logic              txSerialOut, txSerialOutOe, farClk, farSync, rxSerialIn;
  logic              rxBitClockDrive, rxBitClockOe, rxFrameSyncDrive, rxFrameSyncOe;
  int                capCount, errCount, checkCount;

  // Pin levels: driver if enabled, else pull-up or far end
  wire txBitClock  = txBitClockOe ? txBitClockDrive : 1'b1;
  wire txFrameSync = txFrameSyncOe ? txFrameSyncDrive : 1'b1;
  wire txLine      = txSerialOutOe ? txSerialOut : 1'b1;
  wire rxBitClock  = rxBitClockOe ? rxBitClockDrive : farClk;
  wire rxFrameSync = rxFrameSyncOe ? rxFrameSyncDrive : farSync;
  wire [4:0] oes   = {txBitClockOe, txFrameSyncOe, rxBitClockOe, rxFrameSyncOe, txSerialOutOe};

  always #2.5 clk_sys = ~clk_sys;

  fsp_port_pins u_dut (
    .clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .txBitClock, .txBitClockDrive, .txBitClockOe, .txFrameSync, .txFrameSyncDrive,
    .txFrameSyncOe, .txSerialOut, .txSerialOutOe, .rxBitClock, .rxBitClockDrive,
    .rxBitClockOe, .rxFrameSync, .rxFrameSyncDrive, .rxFrameSyncOe, .rxSerialIn
  );

  fsp_far_end u_far (
    .txClk(txBitClock), .txSync(txFrameSync), .txLine, .txFall,
    .rxClk(farClk), .rxSync(farSync), .rxData(rxSerialIn), .capWord, .capCount
  );

  // Verdict and end of run
  task automatic stopTest();
    $display("Comparisons %0d, mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stopTest

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One AHB-Lite single transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 500);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 500);
    rdv = hrdata;
    if (n >= 500) begin
      errCount++;
      stopTest();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, '0);
    check(what, rdv, exp);
    check("hresp", {31'h0, hresp}, '0);
  endtask : rdc

  // Bounded waits: a frame captured, or a status bit set
  task automatic waitCap();
    int c, n;
    c = capCount;
    n = 0;
    while (capCount == c && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 3000) begin
      errCount++;
      stopTest();
    end
  endtask : waitCap

  task automatic pollStat(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, REG_STAT, '0);
      n++;
    end while (rdv[b] !== 1'b1 && n < 400);
    if (n >= 400) begin
      errCount++;
      stopTest();
    end
  endtask : pollStat

  // Both word ends differ so a reversed bit order shows; for 8 to 15 the first bit is zero
  function automatic logic [31:0] pat(input int i);
    return {8'h81 + 8'(i * 16), 16'ha53c, 8'(i)};
  endfunction : pat

  // Main sequence
  initial begin
    {hsel, hwrite, txFall, haddr, htrans, hwdata} = '0;
    errCount = 0;
    checkCount = 0;
    rst = 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    check("oe in reset", {27'h0, oes}, '0);
    rdc(REG_CTRL, {24'h0, CTRL_RST}, "ctrl reset");
    rdc(REG_DIV, {16'h0, DIV_RST}, "div reset");
    rdc(8'h20, '0, "unmapped");
    wr(REG_DIV, 32'hffff);
    rdc(REG_DIV, {16'h0, DIV_MAX}, "div high clamp");
    wr(REG_DIV, '0);
    rdc(REG_DIV, {16'h0, DIV_MIN}, "div low clamp");
    for (int i = 0; i < 8; i++)
      wr(REG_TXDATA, pat(i));
    rdc(REG_STAT, 32'h1 << STAT_TXFULL, "fifo full");
    // Drain with generated clock and sync, then idle frames of ones
    wr(REG_CTRL, 32'h7);
    for (int i = 0; i < 9; i++) begin
      waitCap();
      check("tx frame", capWord, (i < 8) ? pat(i) : '1);
    end
    check("tx drive level", {31'h0, txSerialOut}, '0);
    rdc(REG_STAT, 32'h1 << STAT_TXEMPTY, "fifo empty");
    wr(REG_CTRL, '0);
    wr(REG_TXDATA, pat(9));
    txFall <= 1'b1;
    wr(REG_CTRL, 32'h27);
    waitCap();
    check("tx frame falling", capWord, pat(9));
    // Receive with far-end clock and sync, both sample edges
    for (int m = 0; m < 2; m++) begin
      wr(REG_CTRL, 32'h1 | (m << CTRL_RXFALL));
      u_far.send(pat(20 + m), m[0]);
      @(posedge clk_sys);
      pollStat(STAT_RXVALID);
      rdc(REG_RXDATA, pat(20 + m), "rx frame");
    end
    // Two unread frames set overrun; the clear keeps the newer word
    u_far.send(pat(22), 1'b1);
    u_far.send(pat(23), 1'b1);
    @(posedge clk_sys);
    rdc(REG_STAT, 32'h7, "rx overrun");
    wr(REG_STAT, 32'h1 << STAT_RXOVR);
    rdc(REG_STAT, 32'h5, "overrun cleared");
    rdc(REG_RXDATA, pat(23), "rx newer word");
    // Generated receive clock and sync; idle data line reads as ones
    wr(REG_CTRL, '0);
    wr(REG_CTRL, 32'h19);
    pollStat(STAT_RXVALID);
    rdc(REG_RXDATA, '1, "rx generated");
    wr(REG_CTRL, '0);
    wr(REG_CTRL, 32'h1f);
    @(posedge clk_sys);
    check("pins out", {27'h0, oes}, 32'h1e);
    // Fuse wins over any direction setting and stays set
    wr(REG_CTRL, 32'h9f);
    wr(REG_CTRL, 32'h1f);
    rdc(REG_STAT, (32'h1 << STAT_FUSE) | (32'h1 << STAT_TXEMPTY), "fuse status");
    check("pins fused", {27'h0, oes}, '0);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    rdc(REG_CTRL, '0, "ctrl second reset");
    check("oe second reset", {27'h0, oes}, '0);
    stopTest();
  end
endmodule : fsp_port_pins_tb
